// ===== pkg/sss_pkg.sv
// Constants and types for the synchronous serial shifter
//Operation
//R1 - Drive output bits on falling clock edge, sample input bits on rising edge.
//R2 - Two-bit mode field selects transmit-only, receive-only or full duplex.
//R3 - Software loads buffer, then writing start bit begins transmission.
//R4 - Buffered byte moves to shift register, leaves serial output LSB first.
//R5 - Moving transmit byte empties buffer and raises the serial interrupt.
//R6 - Internal clock transmit: stop clock after 8 bits until buffer is written.
//R7 - External clock transmit: software loads buffer before next byte starts.
//R8 - Output holds last bit of previous byte until first falling edge.
//R9 - Clearing start bit mid-transmit finishes the byte, then clears active flag.
//R10 - Setting inhibit during transmit aborts at once and clears active flag.
//R11 - External clock: clear start bit before next byte, else dummy byte sent.
//R12 - Receive mode: start bit enables reception, input shifted LSB first.
//R13 - After 8 received bits, copy to buffer and raise buffer-full interrupt.
//R14 - Internal clock receive: halt clock until software reads the buffer.
//R15 - Clearing start mid-receive completes byte into buffer, then flag clears.
//R16 - Setting inhibit during reception aborts at once and clears active flag.
//R17 - Changing transfer mode discards buffer contents.
//R18 - Full duplex: drive on falling, sample on rising, buffer and interrupt per byte.
//R19 - Full duplex: software reads received byte before writing next one.
//R20 - Internal clock duplex: wait until byte is read and next one written.
//R21 - External clock duplex: read and write before next shifting starts.
//R22 - Duplex: start clear finishes byte; inhibit aborts; both clear active flag.
//R23 - Internal clock mode generates one of seven rates onto clock pin.
//R24 - Clock source field 111 selects the external clock on the pin.
//R25 - Internal clock pin sits high when a transfer begins.
//R26 - Active flag sets on start and stays set while shifting.
package sss_pkg;
    localparam logic [1:0] ADDR_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_DATA   = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam int         CTRL_START  = 7;
    localparam int         CTRL_INH    = 6;
    localparam int         CTRL_MODE   = 4;
    localparam int         CTRL_SRC    = 0;
    localparam int         STAT_ACTIVE = 7;
    localparam int         STAT_FULL   = 6;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [2:0] SRC_EXT     = 3'h7;
    localparam logic [3:0] BITS_BYTE   = 4'h8;
    localparam logic [1:0] MODE_TX     = 2'h0;
    localparam logic [1:0] MODE_RX     = 2'h1;
    localparam logic [1:0] MODE_TRX    = 2'h2;
    localparam int         DIV_BASE    = 4;
    typedef enum logic [2:0] {
        SSS_IDLE  = 3'b001,
        SSS_SHIFT = 3'b010,
        SSS_WAIT  = 3'b100
    } sss_state_t;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sss_bus_t;
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic so;
    } sss_pins_t;
endpackage

// ===== verilog/sss_shifter.sv
// Clock-synchronous 8-bit serial shifter with register port
`timescale 1ns/1ns
module sss_shifter #(
    parameter int DIV_BASE = sss_pkg::DIV_BASE
) (
    input  wire logic                core_clk_i,
    input  wire logic                resetn_i,
    input  wire sss_pkg::sss_bus_t   bus_i,
    output logic [7:0]               rdata_o,
    input  wire logic                sck_i,
    input  wire logic                si_i,
    output sss_pkg::sss_pins_t       pins_o,
    output logic                     serial_iface_irq_o
);
    logic [7:0]            sio_control_one_ff;
    logic [7:0]            shared_data_buffer_ff;
    logic [7:0]            shreg_ff;
    logic [3:0]            bitcnt_ff;
    logic                  buf_full_ff;
    logic                  rx_unread_ff;
    logic                  active_ff;
    logic                  irq_ff;
    logic [7:0]            rdata_ff;
    sss_pkg::sss_state_t   state_ff;
    logic [2:0]            sck_sync_ff;
    logic [1:0]            si_sync_ff;
    logic                  sck_int_ff;
    logic                  so_ff;
    logic [15:0]           div_ff;
    logic                  fall_ev;
    logic                  rise_ev;
    logic                  tick;
    logic                  ext_clk;
    logic [1:0]            mode;
    logic                  wr_ctrl;
    logic                  wr_data;
    logic                  rd_data;
    logic                  rx_on;
    logic                  tx_on;
    logic                  start_req;
    logic                  byte_done;
    logic                  inhibit;
    logic [15:0]           div_lim;

    assign mode    = sio_control_one_ff[sss_pkg::CTRL_MODE +: 2];
    assign ext_clk = sio_control_one_ff[sss_pkg::CTRL_SRC +: 3] == sss_pkg::SRC_EXT; // R24
    assign wr_ctrl = bus_i.wr && bus_i.addr == sss_pkg::ADDR_CTRL;
    assign wr_data = bus_i.wr && bus_i.addr == sss_pkg::ADDR_DATA;
    assign rd_data = bus_i.rd && bus_i.addr == sss_pkg::ADDR_DATA;
    assign inhibit = wr_ctrl && bus_i.wdata[sss_pkg::CTRL_INH];
    assign rx_on   = mode != sss_pkg::MODE_TX; // R2
    assign tx_on   = mode != sss_pkg::MODE_RX; // R2

    // Seven internal rates: divider limit plus one doubles per source code
    function automatic logic [15:0] rate_limit(input logic [2:0] src);
        rate_limit = 16'(DIV_BASE << src) - 16'h0001; // R23
    endfunction
    assign div_lim = rate_limit(sio_control_one_ff[sss_pkg::CTRL_SRC +: 3]);

    // Pin synchronisers; edges are found past the second stage only
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_sync_ff <= 3'h7;
            si_sync_ff  <= 2'h0;
        end else begin
            sck_sync_ff <= {sck_sync_ff[1:0], sck_i};
            si_sync_ff  <= {si_sync_ff[0], si_i};
        end
    end

    // Internal clock: half-period ticks while shifting
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_ff <= 16'h0000;
        end else if (state_ff != sss_pkg::SSS_SHIFT || ext_clk || div_ff == div_lim) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end
    assign tick = state_ff == sss_pkg::SSS_SHIFT && !ext_clk && div_ff == div_lim;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_int_ff <= 1'b1;
        end else if (state_ff != sss_pkg::SSS_SHIFT) begin
            sck_int_ff <= 1'b1; // R25
        end else if (tick) begin
            sck_int_ff <= ~sck_int_ff; // R23
        end
    end

    always_comb begin
        if (ext_clk) begin
            fall_ev = sck_sync_ff[2] && !sck_sync_ff[1];
            rise_ev = !sck_sync_ff[2] && sck_sync_ff[1];
        end else begin
            fall_ev = tick && sck_int_ff;
            rise_ev = tick && !sck_int_ff;
        end
    end

    assign byte_done = rise_ev && bitcnt_ff == sss_pkg::BITS_BYTE - 4'h1;
    // Next byte may begin: buffer loaded for transmit, emptied for receive
    assign start_req = sio_control_one_ff[sss_pkg::CTRL_START]
                     && (mode == sss_pkg::MODE_RX ? !buf_full_ff
                        : (mode == sss_pkg::MODE_TX ? buf_full_ff
                           : buf_full_ff && !rx_unread_ff)); // R20

    // Control register; inhibit is a strobe and does not stay set
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sio_control_one_ff <= sss_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            sio_control_one_ff <= bus_i.wdata & ~(8'h01 << sss_pkg::CTRL_INH);
        end
    end

    // Sequencer
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff  <= sss_pkg::SSS_IDLE;
            bitcnt_ff <= 4'h0;
            active_ff <= 1'b0;
        end else if (inhibit) begin
            state_ff  <= sss_pkg::SSS_IDLE; // R10 R16 R22
            bitcnt_ff <= 4'h0;
            active_ff <= 1'b0;
        end else begin
            case (state_ff)
                sss_pkg::SSS_IDLE, sss_pkg::SSS_WAIT: begin
                    if (start_req) begin
                        state_ff  <= sss_pkg::SSS_SHIFT;
                        bitcnt_ff <= 4'h0;
                        active_ff <= 1'b1; // R26 R3 R12
                    end else if (!sio_control_one_ff[sss_pkg::CTRL_START]) begin
                        state_ff  <= sss_pkg::SSS_IDLE;
                        active_ff <= 1'b0; // R9 R15 R22
                    end else if (ext_clk && fall_ev) begin
                        state_ff  <= sss_pkg::SSS_SHIFT; // R11 R7 R21
                        bitcnt_ff <= 4'h0;
                        active_ff <= 1'b1;
                    end else begin
                        state_ff <= sss_pkg::SSS_WAIT; // R6 R14 R20
                    end
                end
                sss_pkg::SSS_SHIFT: begin
                    if (byte_done) begin
                        state_ff  <= sss_pkg::SSS_WAIT;
                        bitcnt_ff <= 4'h0;
                    end else if (rise_ev) begin
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= sss_pkg::SSS_IDLE;
                end
            endcase
        end
    end

    // Shift register and output pin
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shreg_ff <= 8'h00;
            so_ff    <= 1'b1;
        end else if (state_ff != sss_pkg::SSS_SHIFT && start_req) begin
            shreg_ff <= shared_data_buffer_ff; // R4
        end else if (state_ff == sss_pkg::SSS_SHIFT) begin
            if (fall_ev && tx_on) begin
                so_ff <= shreg_ff[0]; // R1 R4 R8 R18
            end
            if (rise_ev) begin
                shreg_ff <= {rx_on ? si_sync_ff[1] : 1'b0, shreg_ff[7:1]}; // R1 R12 R18
            end
        end
    end

    // Data buffer: full flag means loaded for transmit, unread for receive
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shared_data_buffer_ff <= 8'h00;
            buf_full_ff           <= 1'b0;
        end else if (wr_ctrl && bus_i.wdata[sss_pkg::CTRL_MODE +: 2] != mode) begin
            shared_data_buffer_ff <= 8'h00; // R17
            buf_full_ff           <= 1'b0;
        end else if (byte_done && rx_on) begin
            shared_data_buffer_ff <= {si_sync_ff[1], shreg_ff[7:1]}; // R13 R18
            buf_full_ff           <= mode == sss_pkg::MODE_RX ? 1'b1 : buf_full_ff;
        end else if (state_ff != sss_pkg::SSS_SHIFT && start_req && mode != sss_pkg::MODE_RX) begin
            buf_full_ff <= 1'b0; // R5
        end else if (wr_data) begin
            shared_data_buffer_ff <= bus_i.wdata; // R19
            buf_full_ff           <= mode != sss_pkg::MODE_RX;
        end else if (rd_data && mode != sss_pkg::MODE_TX) begin
            buf_full_ff <= mode == sss_pkg::MODE_TRX ? buf_full_ff : 1'b0; // R14
        end
    end

    // Received byte not yet read; in duplex it holds off the next byte
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_unread_ff <= 1'b0;
        end else if (wr_ctrl && bus_i.wdata[sss_pkg::CTRL_MODE +: 2] != mode) begin
            rx_unread_ff <= 1'b0; // R17
        end else if (byte_done && rx_on) begin
            rx_unread_ff <= 1'b1; // R13
        end else if (rd_data) begin
            rx_unread_ff <= 1'b0; // R20
        end
    end

    // Interrupt pulse on buffer empty (transmit) or buffer full (receive)
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (byte_done && rx_on)
                   || (state_ff != sss_pkg::SSS_SHIFT && start_req
                       && mode == sss_pkg::MODE_TX && !inhibit); // R5 R13
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                sss_pkg::ADDR_CTRL:   rdata_ff <= sio_control_one_ff;
                sss_pkg::ADDR_DATA:   rdata_ff <= shared_data_buffer_ff;
                sss_pkg::ADDR_STATUS: rdata_ff <= {active_ff, buf_full_ff, 6'h00};
                default:              rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_o            = rdata_ff;
    assign serial_iface_irq_o = irq_ff;
    assign pins_o.sck_o       = sck_int_ff;
    assign pins_o.sck_oe      = !ext_clk;
    assign pins_o.so          = so_ff;
endmodule // sss_shifter

// ===== verif/sss_shifter_props.sv
// Assertion checker for the serial shifter ports
`timescale 1ns/1ns
module sss_shifter_props #(
    parameter int DIV_BASE = 4
) (
    input wire logic               core_clk_i,
    input wire logic               resetn_i,
    input wire sss_pkg::sss_bus_t  bus_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               sck_i,
    input wire logic               si_i,
    input wire sss_pkg::sss_pins_t pins_o,
    input wire logic               serial_iface_irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [2:0]  src_ff;
    logic        inh_ff;
    logic [15:0] low_ff;
    wire         wr_c = bus_i.wr && bus_i.addr == sss_pkg::ADDR_CTRL;
    // Shadow of the rate field and of a pending abort
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_ff <= 3'h0;
            inh_ff <= 1'b0;
        end else if (wr_c) begin
            src_ff <= bus_i.wdata[2:0];
            inh_ff <= bus_i.wdata[sss_pkg::CTRL_INH];
        end
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) low_ff <= 16'h0;
        else low_ff <= pins_o.sck_o ? 16'h0 : low_ff + 16'h1;
    end
    a_so_on_fall: assert property (
        pins_o.sck_oe && $changed(pins_o.so) |-> !pins_o.sck_o || !$past(pins_o.sck_o))
        else $error("serial out moved away from a falling clock");
    a_oe_source: assert property (
        wr_c |=> pins_o.sck_oe == ($past(bus_i.wdata[2:0]) != sss_pkg::SRC_EXT))
        else $error("clock pin enable does not follow source field");
    a_start_high: assert property (
        wr_c && bus_i.wdata[sss_pkg::CTRL_START] && bus_i.wdata[2:0] != sss_pkg::SRC_EXT
        |=> pins_o.sck_o [*2]) else $error("clock pin not high at transfer start");
    a_low_phase: assert property (
        pins_o.sck_oe && $rose(pins_o.sck_o) && !inh_ff |-> low_ff == 16'(DIV_BASE << src_ff))
        else $error("clock low phase has wrong length");
    a_tx_irq: assert property (
        wr_c && bus_i.wdata[7:4] == 4'h8 && bus_i.wdata[2:0] != sss_pkg::SRC_EXT
        && $past(bus_i.wr && bus_i.addr == sss_pkg::ADDR_DATA, 2) |-> ##[1:4] serial_iface_irq_o)
        else $error("no buffer empty interrupt after start");
    a_irq_pulse: assert property (
        serial_iface_irq_o |=> !serial_iface_irq_o) else $error("interrupt longer than a cycle");
    a_inh_stop: assert property (
        wr_c && bus_i.wdata[sss_pkg::CTRL_INH] && pins_o.sck_oe |-> ##2 pins_o.sck_o [*8])
        else $error("clock still running after abort");
    a_so_holds: assert property (
        wr_c && bus_i.wdata[sss_pkg::CTRL_START] |=> $stable(pins_o.so) [*2])
        else $error("serial out changed before first falling clock");
    c_irq: cover property (serial_iface_irq_o);
    c_sck: cover property (pins_o.sck_oe && $rose(pins_o.sck_o));
    c_ext: cover property (!pins_o.sck_oe && $fell(sck_i));
endmodule // sss_shifter_props
bind sss_shifter sss_shifter_props #(.DIV_BASE(DIV_BASE)) u_props (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .sck_i(sck_i), .si_i(si_i),
    .pins_o(pins_o), .serial_iface_irq_o(serial_iface_irq_o));

// ===== verif/sss_periph.sv
// Behavioural model of the external serial peripheral
`timescale 1ns/1ns
module sss_periph (
    input  wire logic       sck_i,
    input  wire logic       so_i,
    input  wire logic       load_i,
    input  wire logic       go_i,
    input  wire logic [7:0] tx_i,
    output logic            sck_o,
    output logic            si_o,
    output logic [7:0]      rx_o
);
    int cnt = 8;
    initial sck_o = 1'b1;
    initial si_o = 1'b1;
    initial rx_o = 8'h00;
    always @(posedge load_i) cnt = 0;
    // Next bit out on the falling edge, LSB first; a spent line keeps toggling
    always @(negedge sck_i) begin
        si_o <= (cnt < 8) ? tx_i[cnt[2:0]] : ~si_o;
        cnt <= cnt + 1;
    end
    always @(posedge sck_i) rx_o <= {so_i, rx_o[7:1]};
    // Eight external clocks per burst, idle high between bursts
    always @(posedge go_i) repeat (8) begin
        #80 sck_o = 1'b0;
        #80 sck_o = 1'b1;
    end
endmodule // sss_periph

// ===== verif/tb_sss_shifter.sv
// Self-checking bench for the synchronous serial shifter
`timescale 1ns/1ns
module tb_sss_shifter;
    localparam logic [1:0] C = sss_pkg::ADDR_CTRL;
    localparam logic [1:0] D = sss_pkg::ADDR_DATA;
    localparam logic [1:0] S = sss_pkg::ADDR_STATUS;
    logic               core_clk_i = 1'b0;
    logic               resetn_i = 1'b0;
    sss_pkg::sss_bus_t  bus_i = '0;
    logic [7:0]         rdata_o, ptx = 8'h00, prx, rv;
    sss_pkg::sss_pins_t pins_o;
    logic               irq, ext_sck, si, load = 1'b0, go = 1'b0;
    wire                sck_w = pins_o.sck_oe ? pins_o.sck_o : ext_sck;
    int                 n_errors = 0;
    int                 compares = 0;
    always #10 core_clk_i = ~core_clk_i;
    sss_shifter #(.DIV_BASE(4)) dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .sck_i(sck_w), .si_i(si), .pins_o(pins_o),
        .serial_iface_irq_o(irq));
    sss_periph peer (.sck_i(sck_w), .so_i(pins_o.so), .load_i(load), .go_i(go), .tx_i(ptx),
        .sck_o(ext_sck), .si_o(si), .rx_o(prx));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus_i <= '0;
    endtask
    task automatic rc(input string nm, input logic [1:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        bus_i <= '0;
        #1 chk(nm, e, rdata_o & m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wait_irq(input string nm);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge core_clk_i) #1;
        chk(nm, 8'h01, {7'h0, irq});
    endtask
    task automatic peer_byte(input logic [7:0] d);
        ptx = d;
        load = 1'b1;
        #1 load = 1'b0;
    endtask
    task automatic finish_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        idle(8);
        resetn_i <= 1'b1;
        rc("ctrl", C, 8'hff, 8'h00);
        rc("status", S, 8'hff, 8'h00);
        rc("unmapped", 2'h3, 8'hff, 8'h00);
        chk("sck_idle", 8'h01, {7'h0, pins_o.sck_o});
        wr(D, 8'ha5);
        wr(C, 8'h80);
        wait_irq("tx_irq");
        rc("tx_active", S, 8'h80, 8'h80);
        idle(130);
        chk("tx_byte", 8'ha5, prx);
        wr(D, 8'h3c);
        wait_irq("tx_next_irq");
        idle(90);
        chk("tx_next", 8'h3c, prx);
        chk("so_hold", 8'h00, {7'h0, pins_o.so});
        wr(C, 8'h00);
        idle(8);
        rc("tx_done", S, 8'h80, 8'h00);
        peer_byte(8'hc6);
        wr(C, 8'h90);
        wait_irq("rx_irq");
        idle(40);
        chk("rx_halt", 8'h01, {7'h0, pins_o.sck_o});
        rc("rx_byte", D, 8'hff, 8'hc6);
        wr(C, 8'h10);
        wait_irq("rx_last_irq");
        idle(4);
        rc("rx_done", S, 8'h80, 8'h00);
        wr(C, 8'h00);
        wr(D, 8'h77);
        wr(C, 8'h10);
        rc("mode_discard", D, 8'hff, 8'h00);
        peer_byte(8'h96);
        wr(C, 8'h20);
        wr(D, 8'hc3);
        wr(C, 8'ha0);
        wait_irq("trx_irq");
        chk("trx_out", 8'hc3, prx);
        rc("trx_in", D, 8'hff, 8'h96);
        idle(40);
        chk("trx_wait", 8'hc3, prx);
        wr(C, 8'h20);
        idle(4);
        rc("trx_done", S, 8'h80, 8'h00);
        wr(C, 8'h00);
        wr(D, 8'hff);
        wr(C, 8'h80);
        idle(20);
        wr(C, 8'h40);
        rc("abort", S, 8'h80, 8'h00);
        wr(C, 8'h07);
        #1 chk("ext_oe", 8'h00, {7'h0, pins_o.sck_oe});
        wr(D, 8'h81);
        wr(C, 8'h87);
        #5 go = 1'b1;
        #1 go = 1'b0;
        idle(90);
        chk("ext_byte", 8'h81, prx);
        wr(C, 8'h07);
        idle(4);
        rc("ext_done", S, 8'h80, 8'h00);
        peer_byte(8'h5a);
        wr(C, 8'h27);
        wr(D, 8'he1);
        wr(C, 8'ha7);
        #5 go = 1'b1;
        #1 go = 1'b0;
        idle(90);
        chk("ext_trx_out", 8'he1, prx);
        rc("ext_trx_in", D, 8'hff, 8'h5a);
        wr(C, 8'h27);
        idle(4);
        rc("ext_trx_done", S, 8'h80, 8'h00);
        finish_test();
    end
endmodule // tb_sss_shifter
